// ---- rtl/tm8_pkg.sv ----
/*
  Shared constants, register map, field positions and state types of the
  8-bit timer block. Assumes a 32-bit AXI4-Lite register bus.
*/
package tm8_pkg;
  localparam int REG_ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_COMPARE = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_PIN = 8'h10;

  localparam int CTRL_FORCE_BIT = 7;
  localparam int CTRL_WAVE_LOW_BIT = 6;
  localparam int CTRL_COM_HI = 5;
  localparam int CTRL_COM_LO = 4;
  localparam int CTRL_WAVE_HIGH_BIT = 3;
  localparam int CTRL_CS_HI = 2;
  localparam int CTRL_CS_LO = 0;
  localparam int FLAG_MATCH_BIT = 7;
  localparam int FLAG_OVF_BIT = 6;
  localparam int PIN_DIR_BIT = 0;
  localparam int PIN_PORT_BIT = 1;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_STEP = 8'h01;

  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE = 2'h1;
  localparam logic [1:0] MODE_CTC = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;

  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV32 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  localparam int PRE_W = 10;
  localparam logic [9:0] PRE_STEP = 10'h001;
  localparam logic [9:0] PRE_MASK8 = 10'h007;
  localparam logic [9:0] PRE_MASK32 = 10'h01F;
  localparam logic [9:0] PRE_MASK256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK1024 = 10'h3FF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {DIR_UP, DIR_DOWN} tm8_dir_e;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } tm8_wr_s;

  typedef struct packed {
    logic awGot;
    logic wGot;
    logic wLane;
    logic [7:0] awAddr;
    logic [7:0] wData;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } tm8_bus_state_s;

  typedef struct packed {
    logic [9:0] pre;
    logic [2:0] sync;
    logic level;
  } tm8_tick_state_s;

  typedef struct packed {
    logic waveLow;
    logic waveHigh;
    logic [1:0] comAct;
    logic [2:0] tickSel;
    logic [7:0] count;
    logic [7:0] compareSw;
    logic [7:0] compareBuf;
    logic matchFlag;
    logic ovfFlag;
    tm8_dir_e dir;
    logic waveOut;
    logic blockMatch;
    logic pinDir;
    logic pinPort;
  } tm8_core_state_s;

  function automatic logic addrMapped(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_COUNT) || (a == ADDR_COMPARE) ||
      (a == ADDR_FLAGS) || (a == ADDR_PIN);
  endfunction
endpackage

// ---- rtl/tm8_tick_gen.sv ----
/*
  Tick source for the timer: free-running prescaler taps and a filtered
  edge detector on the external count pin. Assumes the pin is asynchronous.
*/
`timescale 1ns/1ps
module tm8_tick_gen (
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] tickSourceSel,
  input wire logic extCountPin,
  output logic tick
);
  tm8_pkg::tm8_tick_state_s s_q;
  tm8_pkg::tm8_tick_state_s s_d;
  logic pinChange;

  function automatic logic tapHit(input logic [9:0] p, input logic [9:0] mask);
    return (p & mask) == mask;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.pre = s_q.pre + tm8_pkg::PRE_STEP;
    s_d.sync = {s_q.sync[1:0], extCountPin};
    // Pin is watched whatever its direction, so software can drive it
    pinChange = (s_q.sync[1] == s_q.sync[2]) && (s_q.sync[2] != s_q.level);
    if (pinChange) begin
      s_d.level = s_q.sync[2];
    end
    case (tickSourceSel)
      tm8_pkg::CS_STOP: tick = 1'b0;
      tm8_pkg::CS_DIV1: tick = 1'b1;
      tm8_pkg::CS_DIV8: tick = tapHit(s_q.pre, tm8_pkg::PRE_MASK8);
      tm8_pkg::CS_DIV32: tick = tapHit(s_q.pre, tm8_pkg::PRE_MASK32);
      tm8_pkg::CS_DIV256: tick = tapHit(s_q.pre, tm8_pkg::PRE_MASK256);
      tm8_pkg::CS_DIV1024: tick = tapHit(s_q.pre, tm8_pkg::PRE_MASK1024);
      tm8_pkg::CS_EXT_FALL: tick = pinChange && !s_q.sync[2];
      tm8_pkg::CS_EXT_RISE: tick = pinChange && s_q.sync[2];
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ---- rtl/tm8_axil_slave.sv ----
/*
  AXI4-Lite slave front end: turns bus writes into one-cycle register
  write requests and answers reads from the core's read mux. Assumes
  one outstanding write and one outstanding read.
*/
`timescale 1ns/1ps
module tm8_axil_slave #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output tm8_pkg::tm8_wr_s wrReq,
  output logic [7:0] rdAddr,
  input wire logic [7:0] rdData
);
  tm8_pkg::tm8_bus_state_s s_q;
  tm8_pkg::tm8_bus_state_s s_d;
  logic fire;

  always_comb begin
    s_d = s_q;
    awready = !s_q.awGot && !s_q.bvalid;
    wready = !s_q.wGot && !s_q.bvalid;
    arready = !s_q.rvalid;
    rdAddr = araddr[7:0];
    if (awvalid && awready) begin
      s_d.awGot = 1'b1;
      s_d.awAddr = awaddr[7:0];
    end
    if (wvalid && wready) begin
      s_d.wGot = 1'b1;
      s_d.wData = wdata[7:0];
      s_d.wLane = wstrb[0];
    end
    fire = s_q.awGot && s_q.wGot && !s_q.bvalid;
    if (fire) begin
      s_d.awGot = 1'b0;
      s_d.wGot = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = tm8_pkg::addrMapped(s_q.awAddr) ? tm8_pkg::RESP_OKAY : tm8_pkg::RESP_SLVERR;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rdData;
      s_d.rresp = tm8_pkg::addrMapped(rdAddr) ? tm8_pkg::RESP_OKAY : tm8_pkg::RESP_SLVERR;
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    // Low byte lane carries every register
    wrReq.en = fire && s_q.wLane && tm8_pkg::addrMapped(s_q.awAddr);
    wrReq.addr = s_q.awAddr;
    wrReq.data = s_q.wData;
  end

  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata = {24'h000000, s_q.rdata};
  assign rresp = s_q.rresp;

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ---- rtl/tm8_timer.sv ----
/*
  Top of the 8-bit timer/counter: mode control, counter, compare unit and
  waveform pin logic behind an AXI4-Lite slave. Assumes a single 50 MHz
  clock, synchronous reset, and an external interrupt controller that
  pulses the vector-taken inputs.
*/
// Our own choices: register access over AXI4-Lite and the placing of the registers.
// Functional notes
// - Forced compare acts only in non-PWM modes
// - Force applies compare action from field written with it
// - Force sets no flag, never clears counter
// - Force bit always reads zero
// - Mode bits: high at 3, low at 6
// - Top, compare buffering and overflow point per mode
// - Action field nonzero overrides pin; direction enables
// - Non-PWM: off, toggle, clear, set on match
// - Fast PWM: clear/set on match, opposite at top
// - Phase PWM: up-match and down-match opposite actions
// - PWM compare equal top ignored; top action kept
// - Tick source: stop, 1, 8, 32, 256, 1024
// - Codes 110/111 count external falling/rising edges
// - External pin counts even when driven out
// - Counter readable and writable by software
// - Counter write blocks match on next tick
// - Flags cleared by vector taken or one-write
// - Compare value checked continuously against counter
`timescale 1ns/1ps
module tm8_timer (
  input wire logic clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic extCountPin,
  input wire logic matchVectorTaken,
  input wire logic overflowVectorTaken,
  output logic waveformOutPin,
  output logic waveformOutOe,
  output logic matchFlag,
  output logic overflowFlag
);
  tm8_pkg::tm8_core_state_s s_q;
  tm8_pkg::tm8_core_state_s s_d;
  tm8_pkg::tm8_wr_s wr;
  logic [7:0] rdAddr;
  logic [7:0] rdData;
  logic tick;
  logic [1:0] mode;
  logic [1:0] newMode;
  logic pwm;
  logic [7:0] cmp;
  logic matchEv;
  logic ignoreMatch;
  logic atTop;
  logic forceHit;

  function automatic logic isPwm(input logic [1:0] m);
    return (m == tm8_pkg::MODE_FAST) || (m == tm8_pkg::MODE_PHASE);
  endfunction

  // Compare action outside PWM, shared by matches and forced compares
  function automatic logic nonPwmAction(input logic [1:0] com, input logic cur);
    case (com)
      tm8_pkg::COM_TOGGLE: return !cur;
      tm8_pkg::COM_CLEAR: return 1'b0;
      tm8_pkg::COM_SET: return 1'b1;
      default: return cur;
    endcase
  endfunction

  tm8_axil_slave #(
    .ADDR_W(tm8_pkg::REG_ADDR_W)
  ) u_bus (
    .clk(clk),
    .srst(srst),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .awaddr(s_axi_awaddr),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .bresp(s_axi_bresp),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .araddr(s_axi_araddr),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .wrReq(wr),
    .rdAddr(rdAddr),
    .rdData(rdData)
  );

  tm8_tick_gen u_tick (
    .clk(clk),
    .srst(srst),
    .tickSourceSel(s_q.tickSel),
    .extCountPin(extCountPin),
    .tick(tick)
  );

  always_comb begin
    s_d = s_q;
    mode = {s_q.waveHigh, s_q.waveLow};
    pwm = isPwm(mode);
    newMode = {wr.data[tm8_pkg::CTRL_WAVE_HIGH_BIT], wr.data[tm8_pkg::CTRL_WAVE_LOW_BIT]};
    // Buffered compare in PWM, live value otherwise
    cmp = pwm ? s_q.compareBuf : s_q.compareSw;
    if (!pwm) begin
      s_d.compareBuf = s_q.compareSw;
    end
    ignoreMatch = pwm && (cmp == tm8_pkg::COUNT_TOP) && s_q.comAct[1];
    matchEv = tick && (s_q.count == cmp) && !s_q.blockMatch;
    atTop = tick && (s_q.count == tm8_pkg::COUNT_TOP) && ((mode == tm8_pkg::MODE_FAST) ||
      (mode == tm8_pkg::MODE_PHASE && s_q.dir == tm8_pkg::DIR_UP && ignoreMatch));
    forceHit = wr.en && (wr.addr == tm8_pkg::ADDR_CTRL) &&
      wr.data[tm8_pkg::CTRL_FORCE_BIT] && !isPwm(newMode);

    // Clears first so that a same-cycle set wins
    if (matchVectorTaken || (wr.en && wr.addr == tm8_pkg::ADDR_FLAGS &&
        wr.data[tm8_pkg::FLAG_MATCH_BIT])) begin
      s_d.matchFlag = 1'b0;
    end
    if (overflowVectorTaken || (wr.en && wr.addr == tm8_pkg::ADDR_FLAGS &&
        wr.data[tm8_pkg::FLAG_OVF_BIT])) begin
      s_d.ovfFlag = 1'b0;
    end

    if (tick) begin
      s_d.blockMatch = 1'b0;
      if (matchEv) begin
        s_d.matchFlag = 1'b1;
      end
      case (mode)
        tm8_pkg::MODE_CTC: begin
          if (s_q.count == cmp) begin
            s_d.count = tm8_pkg::COUNT_BOTTOM;
          end else begin
            s_d.count = s_q.count + tm8_pkg::COUNT_STEP;
          end
          if (s_q.count == tm8_pkg::COUNT_TOP) begin
            s_d.ovfFlag = 1'b1;
          end
        end
        tm8_pkg::MODE_PHASE: begin
          if (s_q.dir == tm8_pkg::DIR_UP) begin
            if (s_q.count == tm8_pkg::COUNT_TOP) begin
              s_d.dir = tm8_pkg::DIR_DOWN;
              s_d.count = s_q.count - tm8_pkg::COUNT_STEP;
            end else begin
              s_d.count = s_q.count + tm8_pkg::COUNT_STEP;
            end
          end else begin
            if (s_q.count == tm8_pkg::COUNT_BOTTOM) begin
              s_d.dir = tm8_pkg::DIR_UP;
              s_d.count = s_q.count + tm8_pkg::COUNT_STEP;
              s_d.ovfFlag = 1'b1;
            end else begin
              s_d.count = s_q.count - tm8_pkg::COUNT_STEP;
            end
          end
        end
        default: begin
          s_d.count = s_q.count + tm8_pkg::COUNT_STEP;
          if (s_q.count == tm8_pkg::COUNT_TOP) begin
            s_d.ovfFlag = 1'b1;
          end
        end
      endcase
      // Double-buffered compare loads at top
      if (pwm && s_q.count == tm8_pkg::COUNT_TOP) begin
        s_d.compareBuf = s_q.compareSw;
      end
      if (matchEv && !ignoreMatch) begin
        case (mode)
          tm8_pkg::MODE_FAST: begin
            if (s_q.comAct == tm8_pkg::COM_CLEAR) begin
              s_d.waveOut = 1'b0;
            end else if (s_q.comAct == tm8_pkg::COM_SET) begin
              s_d.waveOut = 1'b1;
            end
          end
          tm8_pkg::MODE_PHASE: begin
            if (s_q.comAct == tm8_pkg::COM_CLEAR) begin
              s_d.waveOut = (s_q.dir == tm8_pkg::DIR_DOWN);
            end else if (s_q.comAct == tm8_pkg::COM_SET) begin
              s_d.waveOut = (s_q.dir == tm8_pkg::DIR_UP);
            end
          end
          default: s_d.waveOut = nonPwmAction(s_q.comAct, s_q.waveOut);
        endcase
      end
      if (atTop) begin
        if (s_q.comAct == tm8_pkg::COM_CLEAR) begin
          s_d.waveOut = 1'b1;
        end else if (s_q.comAct == tm8_pkg::COM_SET) begin
          s_d.waveOut = 1'b0;
        end
      end
    end

    if (wr.en) begin
      case (wr.addr)
        tm8_pkg::ADDR_CTRL: begin
          s_d.waveLow = wr.data[tm8_pkg::CTRL_WAVE_LOW_BIT];
          s_d.waveHigh = wr.data[tm8_pkg::CTRL_WAVE_HIGH_BIT];
          s_d.comAct = wr.data[tm8_pkg::CTRL_COM_HI:tm8_pkg::CTRL_COM_LO];
          s_d.tickSel = wr.data[tm8_pkg::CTRL_CS_HI:tm8_pkg::CTRL_CS_LO];
        end
        tm8_pkg::ADDR_COUNT: begin
          s_d.count = wr.data;
          s_d.blockMatch = 1'b1;
        end
        tm8_pkg::ADDR_COMPARE: s_d.compareSw = wr.data;
        tm8_pkg::ADDR_PIN: begin
          s_d.pinDir = wr.data[tm8_pkg::PIN_DIR_BIT];
          s_d.pinPort = wr.data[tm8_pkg::PIN_PORT_BIT];
        end
        default: s_d = s_d;
      endcase
    end
    // Strobe only; no flag, counter untouched
    if (forceHit) begin
      s_d.waveOut = nonPwmAction(wr.data[tm8_pkg::CTRL_COM_HI:tm8_pkg::CTRL_COM_LO],
        s_d.waveOut);
    end
  end

  always_comb begin
    case (rdAddr)
      tm8_pkg::ADDR_CTRL: rdData = {1'b0, s_q.waveLow, s_q.comAct, s_q.waveHigh,
        s_q.tickSel};
      tm8_pkg::ADDR_COUNT: rdData = s_q.count;
      tm8_pkg::ADDR_COMPARE: rdData = s_q.compareSw;
      tm8_pkg::ADDR_FLAGS: rdData = {s_q.matchFlag, s_q.ovfFlag, 6'h00};
      tm8_pkg::ADDR_PIN: rdData = {6'h00, s_q.pinPort, s_q.pinDir};
      default: rdData = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.count <= tm8_pkg::COUNT_RESET;
      s_q.compareSw <= tm8_pkg::COMPARE_RESET;
      s_q.compareBuf <= tm8_pkg::COMPARE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Waveform replaces port value; direction bit alone enables driver
  assign waveformOutPin = (s_q.comAct != tm8_pkg::COM_OFF) ? s_q.waveOut : s_q.pinPort;
  assign waveformOutOe = s_q.pinDir;
  assign matchFlag = s_q.matchFlag;
  assign overflowFlag = s_q.ovfFlag;

  property p_forceNoFlag;
    @(posedge clk) disable iff (srst)
    (forceHit && !tick && !s_q.matchFlag) |=> !s_q.matchFlag;
  endproperty
  a_forceNoFlag: assert property (p_forceNoFlag) else $error("forced compare set flag");

  property p_forceToggle;
    @(posedge clk) disable iff (srst)
    (forceHit && !tick && wr.data[tm8_pkg::CTRL_COM_HI:tm8_pkg::CTRL_COM_LO] ==
      tm8_pkg::COM_TOGGLE) |=> (s_q.waveOut != $past(s_q.waveOut));
  endproperty
  a_forceToggle: assert property (p_forceToggle) else $error("force did not toggle");

  property p_forcePwmNone;
    @(posedge clk) disable iff (srst)
    (wr.en && wr.addr == tm8_pkg::ADDR_CTRL && wr.data[tm8_pkg::CTRL_FORCE_BIT] &&
      isPwm(newMode) && !tick) |=> $stable(s_q.waveOut);
  endproperty
  a_forcePwmNone: assert property (p_forcePwmNone) else $error("force acted in PWM");

  property p_ctrlReadZero;
    @(posedge clk) disable iff (srst)
    (rdAddr == tm8_pkg::ADDR_CTRL) |-> !rdData[tm8_pkg::CTRL_FORCE_BIT];
  endproperty
  a_ctrlReadZero: assert property (p_ctrlReadZero) else $error("force bit read one");

  property p_ctcWrap;
    @(posedge clk) disable iff (srst)
    (tick && mode == tm8_pkg::MODE_CTC && s_q.count == s_q.compareSw && !wr.en)
      |=> (s_q.count == tm8_pkg::COUNT_BOTTOM);
  endproperty
  a_ctcWrap: assert property (p_ctcWrap) else $error("clear on match failed");

  property p_phaseOvf;
    @(posedge clk) disable iff (srst)
    (tick && mode == tm8_pkg::MODE_PHASE && s_q.dir == tm8_pkg::DIR_DOWN &&
      s_q.count == tm8_pkg::COUNT_BOTTOM && !wr.en) |=> s_q.ovfFlag ##1 1'b1;
  endproperty
  a_phaseOvf: assert property (p_phaseOvf) else $error("no overflow at bottom");

  property p_blockMatch;
    @(posedge clk) disable iff (srst)
    (s_q.blockMatch && tick && !s_q.matchFlag)
      |=> !s_q.matchFlag;
  endproperty
  a_blockMatch: assert property (p_blockMatch) else $error("match after count write");

  property p_fastTopSet;
    @(posedge clk) disable iff (srst)
    (tick && mode == tm8_pkg::MODE_FAST && s_q.count == tm8_pkg::COUNT_TOP &&
      s_q.comAct == tm8_pkg::COM_CLEAR && !wr.en) |=> s_q.waveOut;
  endproperty
  a_fastTopSet: assert property (p_fastTopSet) else $error("fast PWM top set missing");

  property p_pinOverride;
    @(posedge clk) disable iff (srst)
    (s_q.comAct != tm8_pkg::COM_OFF) |-> (waveformOutPin == s_q.waveOut);
  endproperty
  a_pinOverride: assert property (p_pinOverride) else $error("pin not overridden");

  c_ovf: cover property (@(posedge clk) disable iff (srst) $rose(s_q.ovfFlag));
  c_match: cover property (@(posedge clk) disable iff (srst) $rose(s_q.matchFlag));
  c_force: cover property (@(posedge clk) disable iff (srst) forceHit);
  c_phaseTurn: cover property (@(posedge clk) disable iff (srst)
    mode == tm8_pkg::MODE_PHASE && $rose(s_q.dir == tm8_pkg::DIR_DOWN));
endmodule

// ---- testbench/tb_top.sv ----
/*
  Self-checking bench for the 8-bit timer: register bus, forced compare,
  waveform pin, flags, tick sources and counter access.
  Assumes tm8_timer with its AXI4-Lite map from tm8_pkg and a 50 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] A_CT = tm8_pkg::ADDR_CTRL;
  localparam logic [7:0] A_CN = tm8_pkg::ADDR_COUNT;
  localparam logic [7:0] A_CM = tm8_pkg::ADDR_COMPARE;
  localparam logic [7:0] A_FL = tm8_pkg::ADDR_FLAGS;
  localparam logic [7:0] A_PN = tm8_pkg::ADDR_PIN;
  localparam logic [1:0] OK = tm8_pkg::RESP_OKAY;
  logic clk, srst, awvalid, wvalid, bready, arvalid, rready, extPin, mvt, ovt;
  logic [7:0] awaddr, araddr, v;
  logic [31:0] wdata, rd;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, wOut, wOe, mFlag, oFlag;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata;
  logic [1:0] acts [4];
  int n_fail, compares, seed, i, k, wv, dv;

  tm8_timer dut_u (.clk(clk), .srst(srst), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .extCountPin(extPin), .matchVectorTaken(mvt),
    .overflowVectorTaken(ovt), .waveformOutPin(wOut), .waveformOutOe(wOe),
    .matchFlag(mFlag), .overflowFlag(oFlag));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task complete_run;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task hang(input string nm);
    n_fail++;
    $display("wrong value %s expected done seen timeout", nm);
    complete_run;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int t;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    bready <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (t == 50) hang("write");
    chk("bresp", 32'(er), 32'(rs));
  endtask

  task rdReg(input logic [7:0] a);
    int t;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (t == 50) hang("read");
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    rdReg(a);
    chk("rdata", e, rd);
    chk("rresp", 32'(er), 32'(rs));
  endtask

  task pulse(input int n);
    repeat (n) begin
      @(posedge clk) extPin <= 1'b1;
      repeat (8) @(posedge clk);
      extPin <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask

  task endt(input string nm);
    $display("test %s done", nm);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, extPin, mvt, ovt} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hF};
    n_fail = 0;
    compares = 0;
    seed = 32'hB9E6E90D;
    acts = '{2'h1, 2'h3, 2'h2, 2'h1};
    srst = 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rdc(A_CT, 32'h0, OK);
    rdc(A_CN, 32'h0, OK);
    wr(8'h14, 8'hAA, tm8_pkg::RESP_SLVERR);
    rdc(8'h14, 32'h0, tm8_pkg::RESP_SLVERR);
    for (k = 0; k < 4; k++) begin
      v = 8'($random(seed));
      wr(A_CN, v, OK);
      rdc(A_CN, {24'h0, v}, OK);
    end
    endt("access");
    chk("pinOeOff", 32'h0, 32'(wOe));
    wr(A_PN, 8'h03, OK);
    @(posedge clk);
    chk("portPin", 32'h1, 32'(wOut));
    chk("pinOe", 32'h1, 32'(wOe));
    wr(A_PN, 8'h01, OK);
    wr(A_CM, 8'h55, OK);
    wr(A_CN, 8'h33, OK);
    wv = 0;
    for (k = 0; k < 4; k++) begin
      wr(A_CT, {1'b1, 1'b0, acts[k], 4'h8}, OK);
      wv = (acts[k] == 2'h1) ? 1 - wv : (acts[k] == 2'h3) ? 1 : 0;
      @(posedge clk);
      chk("forcedWave", 32'(wv), 32'(wOut));
      chk("matchFlag", 32'h0, 32'(mFlag));
    end
    rdc(A_CN, 32'h33, OK);
    rdc(A_CT, 32'h18, OK);
    wr(A_CT, 8'hE8, OK);
    repeat (2) @(posedge clk);
    chk("pwmForce", 32'(wv), 32'(wOut));
    rdc(A_CT, 32'h68, OK);
    endt("force");
    wr(A_CT, 8'h00, OK);
    wr(A_FL, 8'hC0, OK);
    wr(A_CN, 8'hF0, OK);
    wr(A_CM, 8'hF8, OK);
    wr(A_CT, 8'h01, OK);
    for (i = 0; i < 100 && oFlag !== 1'b1; i++) @(posedge clk);
    if (i == 100) hang("overflow");
    chk("matchSeen", 32'h1, 32'(mFlag));
    wr(A_CT, 8'h00, OK);
    @(posedge clk) mvt <= 1'b1;
    @(posedge clk) mvt <= 1'b0;
    repeat (2) @(posedge clk);
    chk("vecClear", 32'h0, 32'(mFlag));
    rdc(A_FL, 32'h40, OK);
    wr(A_FL, 8'h40, OK);
    rdc(A_FL, 32'h0, OK);
    wr(A_CN, 8'hFE, OK);
    wr(A_CT, 8'h01, OK);
    for (i = 0; i < 100 && oFlag !== 1'b1; i++) @(posedge clk);
    if (i == 100) hang("overflow");
    wr(A_CT, 8'h00, OK);
    @(posedge clk) ovt <= 1'b1;
    @(posedge clk) ovt <= 1'b0;
    repeat (2) @(posedge clk);
    chk("vecClearOvf", 32'h0, 32'(oFlag));
    endt("flags");
    wr(A_CN, 8'h00, OK);
    wr(A_CM, 8'h10, OK);
    wr(A_CT, 8'h09, OK);
    for (k = 0; k < 6; k++) begin
      repeat (($random(seed) & 31) + 1) @(posedge clk);
      rdReg(A_CN);
      chk("ctcTop", 32'h1, 32'(rd <= 32'h10));
    end
    endt("ctc");
    wr(A_CT, 8'h07, OK);
    wr(A_FL, 8'hC0, OK);
    wr(A_CM, 8'h20, OK);
    wr(A_CN, 8'h20, OK);
    pulse(3);
    chk("blocked", 32'h0, 32'(mFlag));
    rdc(A_CN, 32'h23, OK);
    wr(A_CT, 8'h06, OK);
    pulse(3);
    rdc(A_CN, 32'h26, OK);
    endt("external");
    wr(A_CT, 8'hB0, OK);
    wr(A_FL, 8'hC0, OK);
    wr(A_CM, 8'h80, OK);
    wr(A_CN, 8'h7F, OK);
    wr(A_CT, 8'h6F, OK);
    pulse(2);
    chk("fastMatch", 32'h0, 32'(wOut));
    wr(A_CN, 8'hFE, OK);
    pulse(2);
    chk("fastTop", 32'h1, 32'(wOut));
    chk("fastOvf", 32'h1, 32'(oFlag));
    wr(A_CT, 8'h00, OK);
    wr(A_FL, 8'hC0, OK);
    wr(A_CM, 8'h40, OK);
    wr(A_CN, 8'h3F, OK);
    wr(A_CT, 8'h67, OK);
    pulse(2);
    chk("upMatch", 32'h0, 32'(wOut));
    wr(A_CN, 8'hFF, OK);
    pulse(1);
    chk("noOvfTop", 32'h0, 32'(oFlag));
    wr(A_CN, 8'h41, OK);
    pulse(2);
    chk("downMatch", 32'h1, 32'(wOut));
    wr(A_CN, 8'h01, OK);
    pulse(2);
    chk("phaseOvf", 32'h1, 32'(oFlag));
    endt("pwm");
    for (k = 2; k < 6; k++) begin
      dv = (k == 2) ? 8 : (k == 3) ? 32 : (k == 4) ? 256 : 1024;
      wr(A_CT, 8'h00, OK);
      wr(A_CN, 8'h00, OK);
      wr(A_CT, 8'(k), OK);
      repeat (1000) @(posedge clk);
      wr(A_CT, 8'h00, OK);
      rdReg(A_CN);
      chk("prescale", 32'h1, 32'(rd >= 1000 / dv && rd <= 1000 / dv + 2));
    end
    endt("prescale");
    complete_run;
  end
endmodule
